// >>> rtl/osc_select_map.svh
// Register offsets, field positions and reset values of the oscillator control block
`ifndef OSC_SELECT_MAP_SVH
`define OSC_SELECT_MAP_SVH
`define OSC_CTRL_OFFSET    12'h000
`define OSC_TRIM_OFFSET    12'h010
`define OSC_DIV_MSB        26
`define OSC_DIV_LSB        24
`define OSC_DMA_KEEP_BIT   23
`define OSC_SOSC_RDY_BIT   22
`define OSC_DUAL_WAKE_BIT  21
`define OSC_CUR_MSB        14
`define OSC_CUR_LSB        12
`define OSC_NEW_MSB        10
`define OSC_NEW_LSB        8
`define OSC_LOCK_BIT       7
`define OSC_UPLL_BIT       6
`define OSC_SYSTEM_PLL_BIT       5
`define OSC_SLEEP_SEL_BIT  4
`define OSC_FAIL_BIT       3
`define OSC_SOSC_EN_BIT    1
`define OSC_SWITCH_BIT     0
`define OSC_DIV_RESET      3'h0
`define OSC_TRIM_RESET     6'h00
`define OSC_TRIM_W         6
`endif

// >>> rtl/osc_select_pkg.sv
// Types shared by the oscillator control block
`default_nettype none
package osc_select_pkg;
	// Clock source codes as they appear in the current and new source fields
	typedef enum logic [2:0] {
		SRC_FRC_DIV   = 3'b000,
		SRC_SYS_PLL   = 3'b001,
		SRC_PRIMARY   = 3'b010,
		SRC_RSVD_3    = 3'b011,
		SRC_SECONDARY = 3'b100,
		SRC_LOW_PWR   = 3'b101,
		SRC_BACKUP    = 3'b110,
		SRC_FRC_DIV7  = 3'b111
	} osc_src_t;
endpackage
`default_nettype wire

// >>> rtl/oscillator_select_control.sv
// Oscillator selection and control register block with APB slave
// Operation
// - Divider code selects 1..64,256; resets divide-by-one
// - DMA keep bit lets DMA finish while asleep
// - Secondary ready reads 1 only when stable
// - Dual-speed wake runs fast RC until ready
// - Current source field reports active clock except during a dual-speed wake hold
// - Reset loads new from boot source, current too unless two-speed
// - Lock clears only by reset, blocks switching
// - USB PLL flag reads lock status
// - System PLL flag reads lock status
// - Wait enters sleep or idle by bit
// - Fail monitor sets clock fail flag
// - Writing fail flag one forces switchover
// - Secondary enable bit powers oscillator, cfg reset
// - Switch request clears when switch completes
// - Switch request resets to two-speed boot cfg
// - Writes rejected without unlock
// - Unimplemented control bits read zero
// - Six-bit trim field, resets zero
// - Trim is two's complement offset
`timescale 1ns/1ps
`default_nettype none
`include "osc_select_map.svh"
module oscillator_select_control (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        write_permit,
	input  wire logic [2:0]  boot_source_cfg,
	input  wire logic        two_speed_boot_cfg,
	input  wire logic        secondary_osc_boot_cfg,
	input  wire logic [7:0]  source_ready_raw,
	input  wire logic        secondary_osc_stable_raw,
	input  wire logic        usb_pll_lock_raw,
	input  wire logic        sys_pll_lock_raw,
	input  wire logic        fail_detect_raw,
	input  wire logic        wake_event,
	input  wire logic        wait_exec,
	input  wire logic        periph_irq,
	input  wire logic        irq_dma_trig,
	output logic [2:0]       system_clock_sel,
	output logic [8:0]       fast_rc_divide_ratio,
	output logic signed [5:0] fast_rc_trim_out,
	output logic             secondary_osc_on,
	output logic             enter_sleep,
	output logic             enter_idle,
	output logic             cpu_wake_req,
	output logic             dma_run_in_sleep
);
	// Status bundle width: ready per code plus four single flags
	localparam int ST_W = 12;

	logic [ST_W-1:0] st_meta_reg;   // First synchroniser stage
	logic [ST_W-1:0] st_sync_reg;   // Second stage, safe to use
	logic [7:0]      src_ready;     // Synchronised ready per source code
	logic            sosc_stable;   // Synchronised secondary stable
	logic            upll_lock;     // Synchronised USB PLL lock
	logic            system_pll_lock;     // Synchronised system PLL lock
	logic            fail_det;      // Synchronised monitor failure

	logic [2:0]  divider_sel_reg;   // Fast RC divider code
	logic        dma_keep_reg;      // Sleep DMA keep enable
	logic        dual_wake_reg;     // Dual-speed wake select
	osc_select_pkg::osc_src_t cur_src_reg;  // Active source
	osc_select_pkg::osc_src_t new_src_reg;  // Requested source
	logic        lock_reg;          // Clock configuration lock
	logic        sleep_sel_reg;     // Wait goes to sleep when set
	logic        fail_flag_reg;     // Sticky clock fail flag
	logic        sosc_en_reg;       // Secondary oscillator enable
	logic        switch_req_reg;    // Switch request
	logic [5:0]  trim_reg;          // Fast RC trim
	logic        init_pend_reg;     // Config words not yet loaded
	logic        asleep_reg;        // CPU in sleep
	logic        wake_hold_reg;     // Holding fast RC after wake

	logic        acc;               // Access phase of any transfer
	logic        wr_ok;             // Permitted write this cycle
	logic        hit_ctrl;          // Control register addressed
	logic        hit_trim;          // Trim register addressed
	logic        ctrl_wr;           // Control write takes effect
	logic        sw_fail_set;       // Software forced switchover
	logic        switch_done;       // Requested switch completes
	logic [31:0] ctrl_view;         // Control register read value

	// Two-flop synchroniser for every asynchronous status level
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_meta_reg <= 12'h000;
			st_sync_reg <= 12'h000;
		end else begin
			st_meta_reg <= {source_ready_raw, secondary_osc_stable_raw,
				usb_pll_lock_raw, sys_pll_lock_raw, fail_detect_raw};
			st_sync_reg <= st_meta_reg;
		end
	end
	assign src_ready   = st_sync_reg[11:4];
	assign sosc_stable = st_sync_reg[3];
	assign upll_lock   = st_sync_reg[2];
	assign system_pll_lock   = st_sync_reg[1];
	assign fail_det    = st_sync_reg[0];

	// APB decode; every access completes with no wait state
	assign acc      = psel && penable;
	assign hit_ctrl = (paddr == `OSC_CTRL_OFFSET);
	assign hit_trim = (paddr == `OSC_TRIM_OFFSET);
	assign pready   = 1'b1;
	assign pslverr  = acc && !hit_ctrl && !hit_trim;
	// Unlocked state comes from the system unlock logic
	assign wr_ok    = acc && pwrite && write_permit;
	assign ctrl_wr  = wr_ok && hit_ctrl;
	assign sw_fail_set = ctrl_wr && pwdata[`OSC_FAIL_BIT];
	// Switch completes once the target source reports ready
	assign switch_done = switch_req_reg && !init_pend_reg
		&& src_ready[new_src_reg];

	// Config words are sampled one edge after reset release,
	// since an asynchronous reset may only load constants
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			init_pend_reg <= 1'b1;
		else
			init_pend_reg <= 1'b0;
	end

	// Plain read-write control fields
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			divider_sel_reg <= `OSC_DIV_RESET;
			dma_keep_reg    <= 1'b0;
			dual_wake_reg   <= 1'b0;
			sleep_sel_reg   <= 1'b0;
		end else if (ctrl_wr) begin
			divider_sel_reg <= pwdata[`OSC_DIV_MSB:`OSC_DIV_LSB];
			dma_keep_reg    <= pwdata[`OSC_DMA_KEEP_BIT];
			dual_wake_reg   <= pwdata[`OSC_DUAL_WAKE_BIT];
			sleep_sel_reg   <= pwdata[`OSC_SLEEP_SEL_BIT];
		end
	end

	// Secondary enable: reset value taken from its config bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			sosc_en_reg <= 1'b0;
		else if (init_pend_reg)
			sosc_en_reg <= secondary_osc_boot_cfg;
		else if (ctrl_wr)
			sosc_en_reg <= pwdata[`OSC_SOSC_EN_BIT];
	end

	// Lock: set by software, cleared only by reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			lock_reg <= 1'b0;
		else if (ctrl_wr && pwdata[`OSC_LOCK_BIT])
			lock_reg <= 1'b1;
	end

	// New source: boot value, then software unless locked.
	// Reserved codes are not filtered; software keeps off them.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			new_src_reg <= osc_select_pkg::SRC_FRC_DIV;
		else if (init_pend_reg)
			new_src_reg <= osc_select_pkg::osc_src_t'(boot_source_cfg);
		else if (ctrl_wr && !lock_reg)
			new_src_reg <= osc_select_pkg::osc_src_t'(
				pwdata[`OSC_NEW_MSB:`OSC_NEW_LSB]);
	end

	// Switch request: hardware clear on completion; a new
	// software request in the same cycle wins over the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			switch_req_reg <= 1'b0;
		else if (init_pend_reg)
			switch_req_reg <= two_speed_boot_cfg;
		else if (ctrl_wr && !lock_reg && pwdata[`OSC_SWITCH_BIT])
			switch_req_reg <= 1'b1;
		else if (switch_done)
			switch_req_reg <= 1'b0;
	end

	// Active source: boot value, backup on failure, else switch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			cur_src_reg <= osc_select_pkg::SRC_FRC_DIV;
		else if (init_pend_reg)
			// Two-speed boot runs from fast RC until the switch
			cur_src_reg <= two_speed_boot_cfg ? osc_select_pkg::SRC_FRC_DIV
				: osc_select_pkg::osc_src_t'(boot_source_cfg);
		else if (fail_det || sw_fail_set)
			cur_src_reg <= osc_select_pkg::SRC_BACKUP;
		else if (switch_done)
			cur_src_reg <= new_src_reg;
	end

	// Clock fail flag: hardware or software set wins over clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			fail_flag_reg <= 1'b0;
		else if (fail_det || sw_fail_set)
			fail_flag_reg <= 1'b1;
		else if (ctrl_wr)
			fail_flag_reg <= 1'b0;
	end

	// Trim register, low six bits only
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			trim_reg <= `OSC_TRIM_RESET;
		else if (wr_ok && hit_trim)
			trim_reg <= pwdata[`OSC_TRIM_W-1:0];
	end

	// Sleep entry, wake and the dual-speed hold on fast RC
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			asleep_reg    <= 1'b0;
			wake_hold_reg <= 1'b0;
		end else begin
			if (wait_exec && sleep_sel_reg)
				asleep_reg <= 1'b1;
			else if (wake_event)
				asleep_reg <= 1'b0;
			if (asleep_reg && wake_event && dual_wake_reg
				&& !src_ready[cur_src_reg])
				wake_hold_reg <= 1'b1;
			else if (src_ready[cur_src_reg])
				wake_hold_reg <= 1'b0;
		end
	end

	// Registered outputs toward clock tree, CPU and DMA
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			system_clock_sel     <= 3'h0;
			fast_rc_divide_ratio <= 9'h001;
			fast_rc_trim_out     <= 6'sh00;
			secondary_osc_on     <= 1'b0;
			enter_sleep          <= 1'b0;
			enter_idle           <= 1'b0;
			cpu_wake_req         <= 1'b0;
			dma_run_in_sleep     <= 1'b0;
		end else begin
			system_clock_sel <= wake_hold_reg ? 3'h0 : cur_src_reg;
			// Code 111 skips 128 and goes straight to 256
			fast_rc_divide_ratio <= (divider_sel_reg == 3'h7) ? 9'h100
				: 9'(9'h001 << divider_sel_reg);
			fast_rc_trim_out <= signed'(trim_reg);
			secondary_osc_on <= sosc_en_reg;
			enter_sleep  <= wait_exec && sleep_sel_reg;
			enter_idle   <= wait_exec && !sleep_sel_reg;
			// With DMA keep set, DMA-triggering interrupts during sleep are served without waking
			cpu_wake_req <= periph_irq
				&& !(dma_keep_reg && asleep_reg && irq_dma_trig);
			dma_run_in_sleep <= dma_keep_reg && asleep_reg
				&& irq_dma_trig;
		end
	end

	// Control register read view; gaps stay zero
	always_comb begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[`OSC_DIV_MSB:`OSC_DIV_LSB] = divider_sel_reg;
		ctrl_view[`OSC_DMA_KEEP_BIT]  = dma_keep_reg;
		ctrl_view[`OSC_SOSC_RDY_BIT]  = sosc_stable && sosc_en_reg;
		ctrl_view[`OSC_DUAL_WAKE_BIT] = dual_wake_reg;
		ctrl_view[`OSC_CUR_MSB:`OSC_CUR_LSB] = cur_src_reg;
		ctrl_view[`OSC_NEW_MSB:`OSC_NEW_LSB] = new_src_reg;
		ctrl_view[`OSC_LOCK_BIT]      = lock_reg;
		ctrl_view[`OSC_UPLL_BIT]      = upll_lock;
		ctrl_view[`OSC_SYSTEM_PLL_BIT]      = system_pll_lock;
		ctrl_view[`OSC_SLEEP_SEL_BIT] = sleep_sel_reg;
		ctrl_view[`OSC_FAIL_BIT]      = fail_flag_reg;
		ctrl_view[`OSC_SOSC_EN_BIT]   = sosc_en_reg;
		ctrl_view[`OSC_SWITCH_BIT]    = switch_req_reg;
	end

	// Read mux; unmapped and write cycles return zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite && hit_ctrl)
			prdata = ctrl_view;
		else if (psel && !pwrite && hit_trim)
			prdata = {26'h0000000, trim_reg};
	end

	// Checks
	sequence s_wr_one_fail;
		ctrl_wr && pwdata[`OSC_FAIL_BIT];
	endsequence
	sequence s_backup_flagged;
		##1 (cur_src_reg == osc_select_pkg::SRC_BACKUP) && fail_flag_reg;
	endsequence

	property p_div_ratio;
		@(posedge core_clk) disable iff (!rst_n)
		divider_sel_reg == 3'h7 |=> fast_rc_divide_ratio == 9'h100;
	endproperty
	a_div_ratio: assert property (p_div_ratio) else $error("divider 256 wrong");

	property p_forced_switch;
		@(posedge core_clk) disable iff (!rst_n)
		s_wr_one_fail |-> s_backup_flagged;
	endproperty
	a_forced_switch: assert property (p_forced_switch) else $error("no switchover");

	property p_lock_sticky;
		@(posedge core_clk) disable iff (!rst_n)
		lock_reg |=> lock_reg;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

	property p_lock_blocks_new;
		@(posedge core_clk) disable iff (!rst_n)
		lock_reg && !init_pend_reg |=> $stable(new_src_reg);
	endproperty
	a_lock_blocks_new: assert property (p_lock_blocks_new) else $error("new source moved");

	property p_no_permit;
		@(posedge core_clk) disable iff (!rst_n)
		acc && pwrite && !write_permit && hit_trim |=> $stable(trim_reg);
	endproperty
	a_no_permit: assert property (p_no_permit) else $error("write without permit");

	property p_switch_clear;
		@(posedge core_clk) disable iff (!rst_n)
		switch_done && !ctrl_wr && !fail_det
		|=> !switch_req_reg && cur_src_reg == $past(new_src_reg);
	endproperty
	a_switch_clear: assert property (p_switch_clear) else $error("switch not done");

	property p_fail_set;
		@(posedge core_clk) disable iff (!rst_n)
		fail_det |=> fail_flag_reg;
	endproperty
	a_fail_set: assert property (p_fail_set) else $error("fail flag missed");

	property p_sleep_idle;
		@(posedge core_clk) disable iff (!rst_n)
		wait_exec |=> (enter_sleep == $past(sleep_sel_reg)) && (enter_idle != enter_sleep);
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("wait mode wrong");

	property p_rsvd_zero;
		@(posedge core_clk) disable iff (!rst_n)
		psel && !pwrite && hit_ctrl |-> prdata[31:27] == 5'h00 && prdata[20:15] == 6'h00
			&& prdata[11] == 1'b0 && prdata[2] == 1'b0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

	property p_dma_no_wake;
		@(posedge core_clk) disable iff (!rst_n)
		periph_irq && irq_dma_trig && dma_keep_reg && asleep_reg
		|=> !cpu_wake_req && dma_run_in_sleep;
	endproperty
	a_dma_no_wake: assert property (p_dma_no_wake) else $error("DMA woke CPU");

	property p_sync_lat;
		@(posedge core_clk) disable iff (!rst_n)
		// Three samples, so an attempt opened at reset release waits for both stages
		sys_pll_lock_raw [*3] |=> system_pll_lock;
	endproperty
	a_sync_lat: assert property (p_sync_lat) else $error("PLL flag late");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench for the oscillator select control block
`timescale 1ns/1ps
`default_nettype none
`include "osc_select_map.svh"
module tb_top;
	logic        core_clk;                 // System clock, 100 MHz
	logic        rst_n;                    // Active-low asynchronous reset
	logic [11:0] paddr;                    // APB address
	logic        psel;                     // APB select
	logic        penable;                  // APB enable
	logic        pwrite;                   // APB direction
	logic [31:0] pwdata;                   // APB write data
	logic [31:0] prdata;                   // APB read data
	logic        pready;                   // APB ready
	logic        pslverr;                  // APB error
	logic        write_permit;             // Unlock state from the system
	logic [2:0]  boot_source_cfg;          // Boot clock source
	logic        two_speed_boot_cfg;       // Two-speed boot option
	logic        secondary_osc_boot_cfg;   // Secondary enable at power-on
	logic [7:0]  source_ready_raw;         // Per-source ready levels
	logic        secondary_osc_stable_raw; // Secondary oscillator stable
	logic        usb_pll_lock_raw;         // USB PLL lock
	logic        sys_pll_lock_raw;         // System PLL lock
	logic        fail_detect_raw;          // Fail-safe monitor alarm
	logic        wake_event;               // Wake from low power
	logic        wait_exec;                // Wait instruction executed
	logic        periph_irq;               // Peripheral interrupt
	logic        irq_dma_trig;             // Interrupt triggers a DMA
	logic [2:0]  system_clock_sel;         // Active clock code
	logic [8:0]  fast_rc_divide_ratio;     // Divider ratio
	logic signed [5:0] fast_rc_trim_out;   // Trim copy
	logic        secondary_osc_on;         // Secondary oscillator power
	logic        enter_sleep;              // Sleep entry pulse
	logic        enter_idle;               // Idle entry pulse
	logic        cpu_wake_req;             // CPU wake level
	logic        dma_run_in_sleep;         // DMA served while asleep
	int          fail_count;               // Mismatches seen
	int          comparisons;              // Comparisons made
	logic [8:0]  ratio_tab [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100};

	oscillator_select_control oscillator_select_control_inst (.core_clk(core_clk), .rst_n(rst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .write_permit(write_permit),
		.boot_source_cfg(boot_source_cfg), .two_speed_boot_cfg(two_speed_boot_cfg),
		.secondary_osc_boot_cfg(secondary_osc_boot_cfg), .source_ready_raw(source_ready_raw),
		.secondary_osc_stable_raw(secondary_osc_stable_raw), .usb_pll_lock_raw(usb_pll_lock_raw),
		.sys_pll_lock_raw(sys_pll_lock_raw), .fail_detect_raw(fail_detect_raw),
		.wake_event(wake_event), .wait_exec(wait_exec), .periph_irq(periph_irq),
		.irq_dma_trig(irq_dma_trig), .system_clock_sel(system_clock_sel),
		.fast_rc_divide_ratio(fast_rc_divide_ratio), .fast_rc_trim_out(fast_rc_trim_out),
		.secondary_osc_on(secondary_osc_on), .enter_sleep(enter_sleep), .enter_idle(enter_idle),
		.cpu_wake_req(cpu_wake_req), .dma_run_in_sleep(dma_run_in_sleep));

	// Free-running clock
	always #5 core_clk = ~core_clk;

	// Verdict and end of run; a hang lands here too
	task automatic print_verdict();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Four-state comparison so an unknown never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	// Let a number of clock edges pass
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge core_clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			// A limit that runs out counts as a mismatch and ends the run
			fail_count++;
			print_verdict();
		end else begin
			q = prdata;
			e = pslverr;
			psel    <= 1'h0;
			penable <= 1'h0;
		end
	endtask

	// Register write
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(a, 1'h1, d, q, e);
	endtask

	// Register read compared with the expected word
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(a, 1'h0, 32'h0, q, e);
		chk(q, exp);
	endtask

	// Reset values drawn from the configuration inputs
	task automatic t_reset();
		rd(`OSC_CTRL_OFFSET, 32'h0000_2202);
		rd(`OSC_TRIM_OFFSET, 32'h0000_0000);
		chk({23'h0, fast_rc_divide_ratio}, 32'h1);
		chk({29'h0, system_clock_sel}, 32'h2);
	endtask

	// Trim writes need the permit; upper bits stay zero
	task automatic t_trim();
		write_permit <= 1'h0;
		wr(`OSC_TRIM_OFFSET, 32'h0000_0020);
		rd(`OSC_TRIM_OFFSET, 32'h0000_0000);
		write_permit <= 1'h1;
		wr(`OSC_TRIM_OFFSET, 32'hFFFF_FFE0);
		rd(`OSC_TRIM_OFFSET, 32'h0000_0020);
		cyc(2);
		chk({26'h0, fast_rc_trim_out}, 32'h20);
	endtask

	// Every divider code, with unimplemented bits written as ones
	task automatic t_divider();
		for (int i = 0; i < 8; i++) begin
			wr(`OSC_CTRL_OFFSET, (i << 24) | 32'hF81F_8A06);
			rd(`OSC_CTRL_OFFSET, (i << 24) | 32'h0000_2202);
			cyc(2);
			chk({23'h0, fast_rc_divide_ratio}, {23'h0, ratio_tab[i]});
		end
		wr(`OSC_CTRL_OFFSET, 32'h0000_0202);
	endtask

	// Status flags follow the synchronised raw levels
	task automatic t_status();
		secondary_osc_stable_raw <= 1'h1;
		usb_pll_lock_raw         <= 1'h1;
		sys_pll_lock_raw         <= 1'h1;
		cyc(4);
		rd(`OSC_CTRL_OFFSET, 32'h0040_2262);
		chk({31'h0, secondary_osc_on}, 32'h1);
	endtask

	// Switch waits for the new source, then clears the request
	task automatic t_switch();
		wr(`OSC_CTRL_OFFSET, 32'h0000_0103);
		cyc(4);
		rd(`OSC_CTRL_OFFSET, 32'h0040_2163);
		source_ready_raw <= 8'h02;
		cyc(6);
		rd(`OSC_CTRL_OFFSET, 32'h0040_1162);
		chk({29'h0, system_clock_sel}, 32'h1);
	endtask

	// Sleep entry, DMA kept asleep, dual-speed wake, then idle entry
	task automatic t_power();
		wr(`OSC_CTRL_OFFSET, 32'h00A0_0112);
		@(posedge core_clk) wait_exec <= 1'h1;
		@(posedge core_clk) wait_exec <= 1'h0;
		// The pulse launched at the previous edge is still seen at this one
		@(posedge core_clk) chk({30'h0, enter_sleep, enter_idle}, 32'h2);
		periph_irq   <= 1'h1;
		irq_dma_trig <= 1'h1;
		cyc(3);
		chk({30'h0, cpu_wake_req, dma_run_in_sleep}, 32'h1);
		irq_dma_trig <= 1'h0;
		cyc(3);
		chk({30'h0, cpu_wake_req, dma_run_in_sleep}, 32'h2);
		periph_irq       <= 1'h0;
		source_ready_raw <= 8'h00;
		cyc(4);
		@(posedge core_clk) wake_event <= 1'h1;
		@(posedge core_clk) wake_event <= 1'h0;
		cyc(3);
		chk({29'h0, system_clock_sel}, 32'h0);
		source_ready_raw <= 8'h02;
		cyc(6);
		chk({29'h0, system_clock_sel}, 32'h1);
		wr(`OSC_CTRL_OFFSET, 32'h0000_0102);
		@(posedge core_clk) wait_exec <= 1'h1;
		@(posedge core_clk) wait_exec <= 1'h0;
		@(posedge core_clk) chk({30'h0, enter_sleep, enter_idle}, 32'h1);
	endtask

	// Clock fail set by software and by the monitor
	task automatic t_fail();
		wr(`OSC_CTRL_OFFSET, 32'h0000_010A);
		rd(`OSC_CTRL_OFFSET, 32'h0040_616A);
		wr(`OSC_CTRL_OFFSET, 32'h0000_0102);
		rd(`OSC_CTRL_OFFSET, 32'h0040_6162);
		fail_detect_raw <= 1'h1;
		cyc(4);
		fail_detect_raw <= 1'h0;
		rd(`OSC_CTRL_OFFSET, 32'h0040_616A);
		wr(`OSC_CTRL_OFFSET, 32'h0000_0102);
	endtask

	// Lock blocks switching and survives a clearing write; unmapped read
	task automatic t_lock();
		logic [31:0] q;
		logic        e;
		wr(`OSC_CTRL_OFFSET, 32'h0000_0182);
		wr(`OSC_CTRL_OFFSET, 32'h0000_0403);
		rd(`OSC_CTRL_OFFSET, 32'h0040_61E2);
		apb(12'h020, 1'h0, 32'h0, q, e);
		chk({q[30:0], e}, 32'h1);
	endtask

	// Mid-run reset with two-speed boot clears the lock and reloads sources
	task automatic t_rereset();
		@(posedge core_clk);
		boot_source_cfg        <= 3'h4;
		two_speed_boot_cfg     <= 1'h1;
		secondary_osc_boot_cfg <= 1'h0;
		rst_n                  <= 1'h0;
		cyc(3);
		rst_n <= 1'h1;
		cyc(4);
		rd(`OSC_CTRL_OFFSET, 32'h0000_0461);
		chk({29'h0, system_clock_sel}, 32'h0);
		chk({31'h0, secondary_osc_on}, 32'h0);
	endtask

	// Main sequence
	initial begin
		core_clk = 1'h0;
		rst_n = 1'h0;
		paddr = 12'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		pwdata = 32'h0;
		write_permit = 1'h1;
		boot_source_cfg = 3'h2;
		two_speed_boot_cfg = 1'h0;
		secondary_osc_boot_cfg = 1'h1;
		source_ready_raw = 8'h00;
		secondary_osc_stable_raw = 1'h0;
		usb_pll_lock_raw = 1'h0;
		sys_pll_lock_raw = 1'h0;
		fail_detect_raw = 1'h0;
		wake_event = 1'h0;
		wait_exec = 1'h0;
		periph_irq = 1'h0;
		irq_dma_trig = 1'h0;
		fail_count = 0;
		comparisons = 0;
		cyc(3);
		rst_n <= 1'h1;
		cyc(2);
		t_reset();
		t_trim();
		t_divider();
		t_status();
		t_switch();
		t_power();
		t_fail();
		t_lock();
		t_rereset();
		print_verdict();
	end
endmodule
`default_nettype wire
